// File: hw/bcc_check_if.sv
// check-bit selection signals between control and the check-bit unit
`timescale 1ns/1ps
interface bcc_check_if;
    logic       sw_sel;       // software check bits selected
    logic [7:0] override;     // software data check bits
    logic [7:0] gen_data;     // generator data check bits
    logic [7:0] data_out;     // selected data check bits
    logic       tag_win_wr;   // register write to the tag window
    logic [5:0] tag_win_bits; // check bits carried by that write
    logic [5:0] gen_tag;      // generator tag check bits
    logic [5:0] tag_out;      // selected tag check bits
    modport ctl  (output sw_sel, override, gen_data, tag_win_wr, tag_win_bits, gen_tag,
                  input data_out, tag_out);
    modport unit (input sw_sel, override, gen_data, tag_win_wr, tag_win_bits, gen_tag,
                  output data_out, tag_out);
endinterface

// File: hw/bcc_check_sel.sv
// registered check-bit selection for data and tag writes
`timescale 1ns/1ps
module bcc_check_sel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // selection signals
    bcc_check_if.unit cif
);
    // data check bits: override only when software selects it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cif.data_out <= 8'h00;
        end else if (cif.sw_sel) begin
            cif.data_out <= cif.override;
        end else begin
            cif.data_out <= cif.gen_data;
        end
    end

    // tag check bits: only tag window writes may carry software bits
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cif.tag_out <= 6'h00;
        end else if (cif.sw_sel && cif.tag_win_wr) begin
            cif.tag_out <= cif.tag_win_bits;
        end else begin
            cif.tag_out <= cif.gen_tag;
        end
    end
endmodule

// File: hw/bcc_control.sv
// backup cache control and check-bit override registers
`timescale 1ns/1ps
module bcc_control (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // processor register port
    input  wire logic        ipr_wr,
    input  wire logic        ipr_rd,
    input  wire logic [7:0]  ipr_num,
    input  wire logic [31:0] ipr_wdata,
    output logic      [31:0] ipr_rdata_r,
    output logic             ipr_rvalid_r,
    // cache events
    input  wire logic        uncorr_err,
    input  wire logic        cache_access,
    input  wire logic        bus_cmd_start,
    input  wire logic        time_base_tick,
    // check-bit sources
    input  wire logic [7:0]  gen_data_check,
    input  wire logic        tag_win_wr,
    input  wire logic [5:0]  tag_win_check,
    input  wire logic [5:0]  gen_tag_check,
    // cache steering
    output logic             lookup_en_r,
    output logic             force_hit_r,
    output logic             error_transition_mode_r,
    output logic             ecc_suppress_r,
    output logic             syndrome_load_r,
    output logic [2:0]       tag_rate_r,
    output logic [2:0]       data_rd_rate_r,
    output logic [2:0]       data_wr_rate_r,
    output logic             config_bad_r,
    output logic             timeout_tick_r,
    output logic             pack_disable_r,
    output logic             inject_cmd_parity_fault_r,
    // selected check bits
    output logic [7:0]       data_check_out,
    output logic [5:0]       tag_check_out
);
    // stored cache_control fields
    logic       enable_r;              // cache on
    logic       tag_speed_r;           // slow tag ram
    logic [1:0] data_speed_r;          // data ram speed code
    logic [1:0] size_r;                // cache size code
    logic       force_bit_r;           // forced hit test mode
    logic       suppress_bit_r;        // ignore ecc errors
    logic       software_check_bits_r; // use override bits
    logic       tmo_test_r;            // fast timeout clock
    logic       pack_off_r;            // write packer off
    logic       inject_bit_r;          // parity fault request bit
    logic       inject_armed_r;        // one fault still owed
    logic       soft_error_transition_r;
    logic       hard_error_transition_r;
    // override register, deliberately without reset
    logic [3:0] check_bits_upper_r;
    logic [3:0] check_bits_lower_r;

    // decoded writes
    logic cc_wr;
    logic ov_wr;
    logic hard_set;
    logic hard_clr;
    logic inject_rise;
    assign cc_wr       = ipr_wr && (ipr_num == bcc_pkg::IPR_CACHE_CONTROL);
    assign ov_wr       = ipr_wr && (ipr_num == bcc_pkg::IPR_CHECK_OVERRIDE);
    // error flag is set unless errors are suppressed; enable gates only the
    // mode output, so an error seen while off still shows once the cache is on
    assign hard_set    = uncorr_err && !suppress_bit_r;
    assign hard_clr    = cc_wr && ipr_wdata[bcc_pkg::CC_HARD_TRANS];
    // a fresh fault needs the bit to go from clear to set
    assign inject_rise = cc_wr && ipr_wdata[bcc_pkg::CC_INJECT] && !inject_bit_r;

    // read/write control fields
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_r                <= 1'b0;
            tag_speed_r             <= 1'b0;
            data_speed_r            <= bcc_pkg::DS_FAST;
            size_r                  <= bcc_pkg::SIZE_128K;
            force_bit_r             <= 1'b0;
            suppress_bit_r          <= 1'b0;
            software_check_bits_r   <= 1'b0;
            tmo_test_r              <= 1'b0;
            pack_off_r              <= 1'b0;
            inject_bit_r            <= 1'b0;
            soft_error_transition_r <= 1'b0;
        end else if (cc_wr) begin
            enable_r                <= ipr_wdata[bcc_pkg::CC_ENABLE];
            tag_speed_r             <= ipr_wdata[bcc_pkg::CC_TAG_SPEED];
            data_speed_r            <= ipr_wdata[bcc_pkg::CC_DATA_HI:bcc_pkg::CC_DATA_LO];
            size_r                  <= ipr_wdata[bcc_pkg::CC_SIZE_HI:bcc_pkg::CC_SIZE_LO];
            force_bit_r             <= ipr_wdata[bcc_pkg::CC_FORCE_HIT];
            suppress_bit_r          <= ipr_wdata[bcc_pkg::CC_SUPPRESS];
            software_check_bits_r   <= ipr_wdata[bcc_pkg::CC_SW_CHECK];
            tmo_test_r              <= ipr_wdata[bcc_pkg::CC_TMO_TEST];
            pack_off_r              <= ipr_wdata[bcc_pkg::CC_PACK_OFF];
            inject_bit_r            <= ipr_wdata[bcc_pkg::CC_INJECT];
            soft_error_transition_r <= ipr_wdata[bcc_pkg::CC_SOFT_TRANS];
        end
    end

    // hardware transition flag: set wins over a same-cycle clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hard_error_transition_r <= 1'b0;
        end else if (hard_set) begin
            hard_error_transition_r <= 1'b1;
        end else if (hard_clr) begin
            hard_error_transition_r <= 1'b0;
        end
    end

    // one-shot parity fault: armed by a rising write, spent by one command
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            inject_armed_r <= 1'b0;
        end else if (inject_rise) begin
            inject_armed_r <= 1'b1;
        end else if (bus_cmd_start || (cc_wr && !ipr_wdata[bcc_pkg::CC_INJECT])) begin
            inject_armed_r <= 1'b0;
        end
    end

    // override register: no reset so diagnostic values survive
    always_ff @(posedge ref_clk) begin
        if (ov_wr) begin
            check_bits_upper_r <= ipr_wdata[bcc_pkg::OV_UPPER_HI:bcc_pkg::OV_UPPER_LO];
            check_bits_lower_r <= ipr_wdata[bcc_pkg::OV_LOWER_HI:bcc_pkg::OV_LOWER_LO];
        end
    end

    // rate decode, unused data code falls back to the slowest rate
    logic [2:0] tag_rate_nxt;
    logic [2:0] drd_rate_nxt;
    logic [2:0] dwr_rate_nxt;
    always_comb begin
        tag_rate_nxt = tag_speed_r ? bcc_pkg::TAG_RATE_SLOW : bcc_pkg::TAG_RATE_FAST;
        case (data_speed_r)
            bcc_pkg::DS_FAST: begin
                drd_rate_nxt = bcc_pkg::DRD_RATE_FAST;
                dwr_rate_nxt = bcc_pkg::DWR_RATE_FAST;
            end
            bcc_pkg::DS_MID: begin
                drd_rate_nxt = bcc_pkg::DRD_RATE_MID;
                dwr_rate_nxt = bcc_pkg::DWR_RATE_MID;
            end
            default: begin
                drd_rate_nxt = bcc_pkg::DRD_RATE_SLOW;
                dwr_rate_nxt = bcc_pkg::DWR_RATE_SLOW;
            end
        endcase
    end

    // transition mode only while the cache is on
    logic trans_nxt;
    assign trans_nxt = enable_r && (soft_error_transition_r || hard_error_transition_r);

    // registered steering outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lookup_en_r             <= 1'b0;
            force_hit_r             <= 1'b0;
            error_transition_mode_r <= 1'b0;
            ecc_suppress_r          <= 1'b0;
            syndrome_load_r         <= 1'b0;
            tag_rate_r              <= bcc_pkg::TAG_RATE_FAST;
            data_rd_rate_r          <= bcc_pkg::DRD_RATE_FAST;
            data_wr_rate_r          <= bcc_pkg::DWR_RATE_FAST;
            config_bad_r            <= 1'b0;
            timeout_tick_r          <= 1'b0;
            pack_disable_r          <= 1'b0;
        end else begin
            // lookups stop when off or in transition mode
            lookup_en_r             <= enable_r && !trans_nxt;
            // forced hit needs the cache on
            force_hit_r             <= enable_r && force_bit_r;
            error_transition_mode_r <= trans_nxt;
            ecc_suppress_r          <= suppress_bit_r;
            syndrome_load_r         <= suppress_bit_r && cache_access;
            tag_rate_r              <= tag_rate_nxt;
            data_rd_rate_r          <= drd_rate_nxt;
            data_wr_rate_r          <= dwr_rate_nxt;
            // forbidden pairings and sizes are flagged, not corrected
            config_bad_r            <= (tag_speed_r && data_speed_r == bcc_pkg::DS_FAST)
                                       || (size_r != bcc_pkg::SIZE_128K);
            // test mode ticks every cycle instead of on the time base
            timeout_tick_r          <= tmo_test_r || time_base_tick;
            pack_disable_r          <= pack_off_r;
        end
    end

    // parity fault output mirrors the armed state
    assign inject_cmd_parity_fault_r = inject_armed_r;

    // register read: override reads zero, its contents are not exposed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ipr_rdata_r  <= bcc_pkg::RD_ZERO;
            ipr_rvalid_r <= 1'b0;
        end else begin
            ipr_rvalid_r <= ipr_rd;
            ipr_rdata_r  <= bcc_pkg::RD_ZERO;
            if (ipr_rd && ipr_num == bcc_pkg::IPR_CACHE_CONTROL) begin
                ipr_rdata_r[bcc_pkg::CC_ENABLE]                     <= enable_r;
                ipr_rdata_r[bcc_pkg::CC_TAG_SPEED]                  <= tag_speed_r;
                ipr_rdata_r[bcc_pkg::CC_DATA_HI:bcc_pkg::CC_DATA_LO] <= data_speed_r;
                ipr_rdata_r[bcc_pkg::CC_SIZE_HI:bcc_pkg::CC_SIZE_LO] <= size_r;
                ipr_rdata_r[bcc_pkg::CC_FORCE_HIT]                  <= force_bit_r;
                ipr_rdata_r[bcc_pkg::CC_SUPPRESS]                   <= suppress_bit_r;
                ipr_rdata_r[bcc_pkg::CC_SW_CHECK]                   <= software_check_bits_r;
                ipr_rdata_r[bcc_pkg::CC_TMO_TEST]                   <= tmo_test_r;
                ipr_rdata_r[bcc_pkg::CC_PACK_OFF]                   <= pack_off_r;
                ipr_rdata_r[bcc_pkg::CC_INJECT]                     <= inject_bit_r;
                ipr_rdata_r[bcc_pkg::CC_SOFT_TRANS]                 <= soft_error_transition_r;
                ipr_rdata_r[bcc_pkg::CC_HARD_TRANS]                 <= hard_error_transition_r;
            end
        end
    end

    // check-bit selection unit
    bcc_check_if cif ();
    assign cif.sw_sel       = software_check_bits_r;
    assign cif.override     = {check_bits_upper_r, check_bits_lower_r};
    assign cif.gen_data     = gen_data_check;
    assign cif.tag_win_wr   = tag_win_wr;
    assign cif.tag_win_bits = tag_win_check;
    assign cif.gen_tag      = gen_tag_check;
    bcc_check_sel u_check (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cif     (cif)
    );
    assign data_check_out = cif.data_out;
    assign tag_check_out  = cif.tag_out;

    // checks kept beside the logic
    off_miss_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !enable_r |=> !lookup_en_r)
        else $error("lookup enabled while cache off");
    off_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !enable_r |=> !force_hit_r && !error_transition_mode_r)
        else $error("test bits honoured while cache off");
    tag_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(tag_speed_r) |=> tag_rate_r == ($past(tag_speed_r) ?
        bcc_pkg::TAG_RATE_SLOW : bcc_pkg::TAG_RATE_FAST))
        else $error("tag rate does not follow speed bit");
    data_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        data_speed_r == bcc_pkg::DS_MID |=> data_rd_rate_r == bcc_pkg::DRD_RATE_MID
        && data_wr_rate_r == bcc_pkg::DWR_RATE_MID)
        else $error("middle data rate wrong");
    hard_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        uncorr_err && !suppress_bit_r |=> hard_error_transition_r)
        else $error("uncorrectable error did not set transition flag");
    hard_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        hard_clr && !uncorr_err |=> !hard_error_transition_r
        ##1 hard_error_transition_r == $past(uncorr_err && !suppress_bit_r))
        else $error("transition flag clear misbehaves");
    inject_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        inject_armed_r && bus_cmd_start && !inject_rise |=> !inject_cmd_parity_fault_r)
        else $error("parity fault persisted past one command");
    inject_rearm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cc_wr && ipr_wdata[bcc_pkg::CC_INJECT] && inject_bit_r && !inject_armed_r
        |=> !inject_cmd_parity_fault_r)
        else $error("parity fault rearmed without clearing");
    syndrome_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        suppress_bit_r && cache_access |=> syndrome_load_r)
        else $error("syndrome not captured under suppression");
    sw_check_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        software_check_bits_r ##1 software_check_bits_r && $stable(cif.override)
        |-> data_check_out == cif.override)
        else $error("software check bits not used");
    gen_check_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !software_check_bits_r |=> data_check_out == $past(gen_data_check))
        else $error("generator bits not used");
    tmo_tick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tmo_test_r |=> timeout_tick_r)
        else $error("timeout test did not tick every cycle");
    read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        ipr_rd && ipr_num == bcc_pkg::IPR_CHECK_OVERRIDE
        |=> ipr_rvalid_r && ipr_rdata_r == bcc_pkg::RD_ZERO)
        else $error("override register read not zero");
    // steering, rate and check-bit outputs against the stored fields
    force_hit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        enable_r && force_bit_r |=> force_hit_r)
        else $error("forced hit not active");
    lookup_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        enable_r && !soft_error_transition_r && !hard_error_transition_r |=> lookup_en_r)
        else $error("lookup off while cache on");
    soft_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        enable_r && soft_error_transition_r |=> error_transition_mode_r && !lookup_en_r)
        else $error("soft transition mode not entered");
    size_bad_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        size_r != bcc_pkg::SIZE_128K |=> config_bad_r)
        else $error("bad size not flagged");
    data_fast_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        data_speed_r == bcc_pkg::DS_FAST |=> data_rd_rate_r == bcc_pkg::DRD_RATE_FAST
        && data_wr_rate_r == bcc_pkg::DWR_RATE_FAST)
        else $error("fast data rate wrong");
    syndrome_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(suppress_bit_r && cache_access) |=> !syndrome_load_r)
        else $error("syndrome strobe without cause");
    suppress_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        suppress_bit_r && !hard_error_transition_r |=> !hard_error_transition_r)
        else $error("flag set while errors suppressed");
    inject_arm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        inject_rise |=> inject_cmd_parity_fault_r)
        else $error("parity fault not armed");
    tick_base_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        time_base_tick |=> timeout_tick_r)
        else $error("time base tick lost");
    tick_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !tmo_test_r && !time_base_tick |=> !timeout_tick_r)
        else $error("timeout tick without source");
    pack_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> pack_disable_r == $past(pack_off_r))
        else $error("pack disable not followed");
    tag_win_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        software_check_bits_r && tag_win_wr |=> tag_check_out == $past(tag_win_check))
        else $error("tag window check bits not used");
    tag_gen_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !software_check_bits_r || !tag_win_wr |=> tag_check_out == $past(gen_tag_check))
        else $error("tag generator bits not used");
    override_wr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        ov_wr |=> cif.override == {$past(ipr_wdata[bcc_pkg::OV_UPPER_HI:bcc_pkg::OV_UPPER_LO]),
        $past(ipr_wdata[bcc_pkg::OV_LOWER_HI:bcc_pkg::OV_LOWER_LO])})
        else $error("override nibbles not stored");
    null_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        ipr_rd && ipr_num != bcc_pkg::IPR_CACHE_CONTROL |=> ipr_rdata_r == bcc_pkg::RD_ZERO)
        else $error("unmapped read not zero");
endmodule

// File: hw/bcc_pkg.sv
// constants for the backup cache control block
package bcc_pkg;
    // processor register numbers
    localparam logic [7:0] IPR_CACHE_CONTROL  = 8'hA0;
    localparam logic [7:0] IPR_CHECK_OVERRIDE = 8'hA2;
    // cache_control bit positions
    localparam int CC_ENABLE     = 0;
    localparam int CC_TAG_SPEED  = 1;
    localparam int CC_DATA_LO    = 2;
    localparam int CC_DATA_HI    = 3;
    localparam int CC_SIZE_LO    = 4;
    localparam int CC_SIZE_HI    = 5;
    localparam int CC_FORCE_HIT  = 6;
    localparam int CC_SUPPRESS   = 7;
    localparam int CC_SW_CHECK   = 8;
    localparam int CC_TMO_TEST   = 9;
    localparam int CC_PACK_OFF   = 10;
    localparam int CC_INJECT     = 16;
    localparam int CC_SOFT_TRANS = 30;
    localparam int CC_HARD_TRANS = 31;
    // data_check_bits_override field positions
    localparam int OV_UPPER_LO   = 22;
    localparam int OV_UPPER_HI   = 25;
    localparam int OV_LOWER_LO   = 6;
    localparam int OV_LOWER_HI   = 9;
    // data speed encodings
    localparam logic [1:0] DS_FAST = 2'h0;
    localparam logic [1:0] DS_MID  = 2'h1;
    localparam logic [1:0] DS_SLOW = 2'h2;
    localparam logic [1:0] SIZE_128K = 2'h0;
    // repetition rates in cycles
    localparam logic [2:0] TAG_RATE_FAST = 3'h3;
    localparam logic [2:0] TAG_RATE_SLOW = 3'h4;
    localparam logic [2:0] DRD_RATE_FAST = 3'h2;
    localparam logic [2:0] DRD_RATE_MID  = 3'h3;
    localparam logic [2:0] DRD_RATE_SLOW = 3'h4;
    localparam logic [2:0] DWR_RATE_FAST = 3'h3;
    localparam logic [2:0] DWR_RATE_MID  = 3'h4;
    localparam logic [2:0] DWR_RATE_SLOW = 3'h5;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// File: tb/tb_backup_cache_control_ecc_override.sv
// self-checking bench for the backup cache control and check-bit override registers
`timescale 1ns/1ps
module tb_backup_cache_control_ecc_override;
    // clock and reset
    logic        ref_clk        = 1'b0;
    logic        rstn           = 1'b0;
    // register port
    logic        ipr_wr         = 1'b0;
    logic        ipr_rd         = 1'b0;
    logic [7:0]  ipr_num        = 8'h00;
    logic [31:0] ipr_wdata      = 32'h0000_0000;
    logic [31:0] ipr_rdata_r;
    logic        ipr_rvalid_r;
    // cache events
    logic        uncorr_err     = 1'b0;
    logic        cache_access   = 1'b0;
    logic        bus_cmd_start  = 1'b0;
    logic        time_base_tick = 1'b0;
    // check-bit sources, fixed patterns that differ from the override
    logic [7:0]  gen_data_check = 8'h3C;
    logic        tag_win_wr     = 1'b0;
    logic [5:0]  tag_win_check  = 6'h2A;
    logic [5:0]  gen_tag_check  = 6'h15;
    // steering outputs
    logic        lookup_en_r;
    logic        force_hit_r;
    logic        trans_mode_r;
    logic        ecc_suppress_r;
    logic        syndrome_load_r;
    logic [2:0]  tag_rate_r;
    logic [2:0]  data_rd_rate_r;
    logic [2:0]  data_wr_rate_r;
    logic        config_bad_r;
    logic        timeout_tick_r;
    logic        pack_disable_r;
    logic        inject_r;
    logic [7:0]  data_check_out;
    logic [5:0]  tag_check_out;
    // bookkeeping
    int          miscompares    = 0;
    int          tests_run      = 0;
    int          i;
    logic [1:0]  ds;
    logic        ts;

    // free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // device under test
    bcc_control DUT (
        .ref_clk(ref_clk), .rstn(rstn),
        .ipr_wr(ipr_wr), .ipr_rd(ipr_rd), .ipr_num(ipr_num), .ipr_wdata(ipr_wdata),
        .ipr_rdata_r(ipr_rdata_r), .ipr_rvalid_r(ipr_rvalid_r),
        .uncorr_err(uncorr_err), .cache_access(cache_access),
        .bus_cmd_start(bus_cmd_start), .time_base_tick(time_base_tick),
        .gen_data_check(gen_data_check), .tag_win_wr(tag_win_wr),
        .tag_win_check(tag_win_check), .gen_tag_check(gen_tag_check),
        .lookup_en_r(lookup_en_r), .force_hit_r(force_hit_r),
        .error_transition_mode_r(trans_mode_r), .ecc_suppress_r(ecc_suppress_r),
        .syndrome_load_r(syndrome_load_r), .tag_rate_r(tag_rate_r),
        .data_rd_rate_r(data_rd_rate_r), .data_wr_rate_r(data_wr_rate_r),
        .config_bad_r(config_bad_r), .timeout_tick_r(timeout_tick_r),
        .pack_disable_r(pack_disable_r), .inject_cmd_parity_fault_r(inject_r),
        .data_check_out(data_check_out), .tag_check_out(tag_check_out)
    );

    // verdict and end of run, reached from every path
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one compare for every value, narrow ones zero-extended
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // register write; returns once registered outputs have settled
    task wr(input logic [7:0] num, input logic [31:0] data);
        @(posedge ref_clk);
        ipr_wr    <= 1'b1;
        ipr_num   <= num;
        ipr_wdata <= data;
        @(posedge ref_clk);
        ipr_wr    <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // register read, bounded wait for the answer strobe
    task rd(input logic [7:0] num, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        ipr_rd  <= 1'b1;
        ipr_num <= num;
        @(posedge ref_clk);
        ipr_rd  <= 1'b0;
        #1;
        while (ipr_rvalid_r !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 4) begin
            miscompares++;
            finish_test();
        end else begin
            chk(ipr_rdata_r, exp);
        end
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'hA0, 32'h0000_0000);
        chk({29'h0, tag_rate_r}, 32'h3);
        chk({29'h0, data_rd_rate_r}, 32'h2);
        chk({29'h0, data_wr_rate_r}, 32'h3);
        chk(32'(lookup_en_r), 32'h0);
        // disabled cache ignores forced hit and the soft transition bit
        wr(8'hA0, 32'h4000_0040);
        chk(32'({lookup_en_r, force_hit_r, trans_mode_r}), 32'h0);
        rd(8'hA0, 32'h4000_0040);
        // every speed pairing; code 11 is read as the slowest
        for (i = 0; i < 8; i++) begin
            ts = i[2];
            ds = i[1:0];
            wr(8'hA0, {28'h0, ds, ts, 1'b1});
            chk(32'(lookup_en_r), 32'h1);
            chk(32'(tag_rate_r), ts ? 32'h4 : 32'h3);
            chk(32'(data_rd_rate_r), (ds == 2'h0) ? 32'h2 : (ds == 2'h1) ? 32'h3 : 32'h4);
            chk(32'(data_wr_rate_r), (ds == 2'h0) ? 32'h3 : (ds == 2'h1) ? 32'h4 : 32'h5);
            chk(32'(config_bad_r), (ts && ds == 2'h0) ? 32'h1 : 32'h0);
        end
        wr(8'hA0, 32'h0000_0011);
        chk(32'(config_bad_r), 32'h1);
        // enabled forced hit, then soft transition mode
        wr(8'hA0, 32'h0000_0045);
        chk(32'({lookup_en_r, force_hit_r, trans_mode_r}), 32'h6);
        wr(8'hA0, 32'h4000_0005);
        chk(32'({lookup_en_r, force_hit_r, trans_mode_r}), 32'h1);
        // hard transition set by an uncorrectable error, cleared by writing one
        wr(8'hA0, 32'h0000_0005);
        @(posedge ref_clk);
        uncorr_err <= 1'b1;
        @(posedge ref_clk);
        uncorr_err <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(32'({lookup_en_r, trans_mode_r}), 32'h1);
        rd(8'hA0, 32'h8000_0005);
        wr(8'hA0, 32'h8000_0005);
        rd(8'hA0, 32'h0000_0005);
        // suppression blocks the error and strobes the syndrome capture
        wr(8'hA0, 32'h0000_0085);
        chk(32'(ecc_suppress_r), 32'h1);
        @(posedge ref_clk);
        uncorr_err   <= 1'b1;
        cache_access <= 1'b1;
        @(posedge ref_clk);
        uncorr_err   <= 1'b0;
        cache_access <= 1'b0;
        #1;
        chk(32'(syndrome_load_r), 32'h1);
        rd(8'hA0, 32'h0000_0085);
        // timeout tick source, pack disable
        wr(8'hA0, 32'h0000_0605);
        chk(32'({timeout_tick_r, pack_disable_r}), 32'h3);
        wr(8'hA0, 32'h0000_0005);
        chk(32'({timeout_tick_r, pack_disable_r}), 32'h0);
        // outside test mode the slow time base alone ticks the timeout counter
        @(posedge ref_clk);
        time_base_tick <= 1'b1;
        @(posedge ref_clk);
        time_base_tick <= 1'b0;
        #1;
        chk(32'(timeout_tick_r), 32'h1);
        @(posedge ref_clk);
        #1;
        chk(32'(timeout_tick_r), 32'h0);
        // parity fault lasts one bus command and rearms only through a clear
        wr(8'hA0, 32'h0001_0005);
        chk(32'(inject_r), 32'h1);
        @(posedge ref_clk);
        bus_cmd_start <= 1'b1;
        @(posedge ref_clk);
        bus_cmd_start <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(32'(inject_r), 32'h0);
        wr(8'hA0, 32'h0001_0005);
        chk(32'(inject_r), 32'h0);
        wr(8'hA0, 32'h0000_0005);
        wr(8'hA0, 32'h0001_0005);
        chk(32'(inject_r), 32'h1);
        // override nibbles steer data check bits only with software bits on
        wr(8'hA2, 32'h0280_0140);
        chk(32'(data_check_out), 32'h3C);
        wr(8'hA0, 32'h0000_0105);
        chk(32'(data_check_out), 32'hA5);
        @(posedge ref_clk);
        tag_win_wr <= 1'b1;
        @(posedge ref_clk);
        tag_win_wr <= 1'b0;
        #1;
        chk(32'(tag_check_out), 32'h2A);
        @(posedge ref_clk);
        #1;
        chk(32'(tag_check_out), 32'h15);
        rd(8'hA2, 32'h0000_0000);
        rd(8'hA1, 32'h0000_0000);
        // second reset leaves the override in place
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'hA0, 32'h0000_0000);
        wr(8'hA0, 32'h0000_0100);
        chk(32'(data_check_out), 32'hA5);
        finish_test();
    end
endmodule
